/* File: common/rcbt_map.svh */
// Operation
// RL1: Config-lock pin picks pin or register standard
// RL2: Standard select 0 means B, 1 means A
// RL3: A-standard monitor waits 9us for response
// RL4: A-standard: mode codes carry no data, SA0
// RL5: B-standard: control bit 9 picks 14/30us
// RL6: A-standard: same bit picks 9/21us
// RL7: Select bit 0 short, 1 long
// RL8: Time each memory access against 16us
// RL9: DMA time-out abandons message, optional interrupt
// RL10: Control bits 7 and 8 choose buffer mode
// RL11: Mode 0 is default indexed/ping-pong scheme
// RL12: T/R, subaddress, count select one descriptor
// RL13: Mode 1 words: top, current, bottom
// RL14: Mode 1 receive: info, tag, data at +2
// RL15: Mode 1 transmit: data from +2, then info
// RL16: Wrap current to top at or past bottom
// RL17: Mode 1 writes current back only without error
// RL18: Software leaves 34 spare words past bottom
// RL19: Software reserves two words before packets
// RL20: Circular modes ignore ping-pong; broadcast bit 5
// RL21: Wrap raises gated full/empty message interrupt
// RL22: Mode 2: data top, current, info buffer
// RL23: Mode 2 buffers wrap after message count
// RL24: Mode 2 offset at length resets, current reloads
// RL25: Control bit 9 echoes bit 2 when settled
// RL26: Software freezes ping-pong before servicing buffers
// RL27: Undefined mode combination behaves as mode 0
`ifndef RCBT_MAP_SVH
`define RCBT_MAP_SVH

`define RCB_ADR_CTRL 8'h00
`define RCB_ADR_MASK 8'h04
`define RCB_ADR_STAT 8'h08
`define RCB_ADR_DBASE 8'h0C

`define RCB_CTRL_RST 16'h0000
`define RCB_MASK_RST 16'h0000
`define RCB_DBASE_RST 16'h0000

`define RCB_CTL_PINGPONG_ENABLE 2
`define RCB_CTL_MODE7 7
`define RCB_CTL_MODE8 8
`define RCB_CTL_TOSEL 9
`define RCB_CTL_STDSW 10

`define RCB_MSK_DMA 0
`define RCB_MSK_NRSP 2
`define RCB_MSK_FE 8

`define RCB_ST_DMA 0
`define RCB_ST_FE 1
`define RCB_ST_NRSP 2

`define RCB_CW_PPSEL 2
`define RCB_CW_FEEN 7
`define RCB_INFO_BCAST 5
`define RCB_HDR_WORDS 16'h0002
`define RCB_TAG_OFS 16'h0001
`define RCB_DW_CUR 16'h0002
`define RCB_DW_W4 16'h0003
`define RCB_SA_MC0 5'h00
`define RCB_SA_MC31 5'h1F

`define RCB_CLK_MHZ 125
`define RCB_NR_A_SHORT_US 9
`define RCB_NR_A_LONG_US 21
`define RCB_NR_B_SHORT_US 14
`define RCB_NR_B_LONG_US 30
`define RCB_DMA_TO_US 16
`define RCB_CYC(us) (12'((us) * `RCB_CLK_MHZ))

`endif

/* File: common/rcbt_pkg.sv */
package rcbt_pkg;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_RD0 = 4'h1,
        S_RD1 = 4'h2,
        S_RD2 = 4'h3,
        S_RD3 = 4'h4,
        S_XFER = 4'h5,
        S_INFO = 4'h6,
        S_TAG = 4'h7,
        S_WCA = 4'h8,
        S_WW4 = 4'h9,
        S_WCW = 4'hA
    } rcbt_state_e;

    typedef enum logic [1:0] {
        M_IDX = 2'h0,
        M_CIRC1 = 2'h1,
        M_CIRC2 = 2'h2
    } rcbt_mode_e;

    typedef struct packed {
        logic tr;
        logic [4:0] sa;
        logic [4:0] wc;
        logic bcast;
    } rcbt_cmd_s;

    typedef struct packed {
        logic err;
        logic [15:0] info;
        logic [15:0] tag;
    } rcbt_end_s;

    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } rcbt_mem_s;

    typedef struct packed {
        rcbt_state_e st;
        logic wb_ack;
        logic [31:0] wb_dat;
        logic [15:0] ctrl;
        logic [15:0] mask;
        logic [2:0] status;
        logic [15:0] dbase;
        rcbt_mem_s mem;
        logic [11:0] dtmr;
        rcbt_mode_e mode;
        logic [15:0] desc;
        logic [15:0] cw;
        logic [15:0] top;
        logic [15:0] cur;
        logic [15:0] w4;
        logic [15:0] ptr;
        logic bcast;
        rcbt_end_s fin;
        logic tx_valid;
        logic [15:0] tx_data;
        logic rsp_on;
        logic [11:0] rsp_cnt;
        logic irq_n;
        logic pp_ack;
        logic std_a;
        logic [5:0] word_cnt;
        logic busy;
    } rcbt_state_s;

endpackage

/* File: rtl/rcbt_engine.sv */
`include "rcbt_map.svh"

module rcbt_engine (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_standard_select_pin,
    input wire logic i_config_lock,
    input wire logic i_cmd_valid,
    input wire rcbt_pkg::rcbt_cmd_s i_cmd,
    output logic [5:0] o_word_count,
    output logic o_std_a,
    input wire logic i_rx_valid,
    input wire logic [15:0] i_rx_data,
    input wire logic i_tx_req,
    output logic o_tx_valid,
    output logic [15:0] o_tx_data,
    input wire logic i_end_valid,
    input wire rcbt_pkg::rcbt_end_s i_end,
    output logic o_busy,
    input wire logic i_resp_start,
    input wire logic i_resp_seen,
    output rcbt_pkg::rcbt_mem_s o_mem,
    input wire logic i_mem_ack,
    input wire logic [15:0] i_mem_rdata,
    output logic o_message_interrupt_n
);
    import rcbt_pkg::*;

    rcbt_state_s q;
    rcbt_state_s s;

    logic bus_hit;
    logic [15:0] wmask;
    logic [2:0] ev;
    logic [2:0] clr;
    logic std_a;
    logic is_mc;
    logic [4:0] field;
    logic [11:0] nr_lim;
    logic [7:0] mlen;
    logic [8:0] ncaf;
    logic wrap;
    logic [15:0] newcur;
    logic [2:0] msk;
    logic xfer_rdy;

    always_comb begin
        s = q;
        ev = 3'h0;
        clr = 3'h0;
        s.wb_ack = 1'b0;
        s.tx_valid = 1'b0;
        wmask = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
        bus_hit = i_wb_cyc & i_wb_stb & ~q.wb_ack;
        xfer_rdy = (q.st == S_XFER) & ~q.mem.req;
        // Pin rules only while locked
        std_a = i_config_lock ? i_standard_select_pin
                              : q.ctrl[`RCB_CTL_STDSW]; // RL1 RL2
        s.std_a = std_a;
        is_mc = (i_cmd.sa == `RCB_SA_MC0) |
                ((i_cmd.sa == `RCB_SA_MC31) & ~std_a); // RL4
        field = is_mc ? i_cmd.wc : i_cmd.sa;
        mlen = q.cw[15:8];
        ncaf = {1'b0, q.w4[7:0] & mlen} + 9'h002;
        wrap = 1'b0;
        newcur = q.ptr;

        // One wait state; unmapped reads give zero
        if (bus_hit) begin
            s.wb_ack = 1'b1;
            s.wb_dat = 32'h0000_0000;
            case (i_wb_adr)
                `RCB_ADR_CTRL: begin
                    s.wb_dat[15:0] = q.ctrl;
                    s.wb_dat[`RCB_CTL_TOSEL] = q.pp_ack; // RL25
                    if (i_wb_we) begin
                        s.ctrl = (q.ctrl & ~wmask) | (i_wb_dat[15:0] & wmask);
                    end
                end
                `RCB_ADR_MASK: begin
                    s.wb_dat[15:0] = q.mask;
                    if (i_wb_we) begin
                        s.mask = (q.mask & ~wmask) | (i_wb_dat[15:0] & wmask);
                    end
                end
                `RCB_ADR_STAT: begin
                    s.wb_dat[2:0] = q.status;
                    if (i_wb_we & i_wb_sel[0]) begin
                        clr = i_wb_dat[2:0];
                    end
                end
                `RCB_ADR_DBASE: begin
                    s.wb_dat[15:0] = q.dbase;
                    if (i_wb_we) begin
                        s.dbase = (q.dbase & ~wmask) |
                                  (i_wb_dat[15:0] & wmask);
                    end
                end
                default: begin
                end
            endcase
        end

        // No-response timer
        if (std_a) begin
            nr_lim = q.ctrl[`RCB_CTL_TOSEL] ? `RCB_CYC(`RCB_NR_A_LONG_US)
                   : `RCB_CYC(`RCB_NR_A_SHORT_US); // RL3 RL6 RL7
        end else begin
            nr_lim = q.ctrl[`RCB_CTL_TOSEL] ? `RCB_CYC(`RCB_NR_B_LONG_US)
                   : `RCB_CYC(`RCB_NR_B_SHORT_US); // RL5 RL7
        end
        if (i_resp_start) begin
            s.rsp_on = 1'b1;
            s.rsp_cnt = 12'(nr_lim - 12'h001);
        end else if (q.rsp_on) begin
            if (i_resp_seen) begin
                s.rsp_on = 1'b0;
            end else if (q.rsp_cnt == 12'h000) begin
                s.rsp_on = 1'b0;
                ev[`RCB_ST_NRSP] = 1'b1;
            end else begin
                s.rsp_cnt = 12'(q.rsp_cnt - 12'h001);
            end
        end

        // A request stands until its ack or the 16us time-out
        if (q.mem.req & i_mem_ack) begin
            s.mem.req = 1'b0;
            s.dtmr = 12'h000;
        end else if (q.mem.req) begin
            s.dtmr = 12'(q.dtmr + 12'h001);
        end

        case (q.st)
            S_IDLE: begin
                // Freeze settles only between messages
                s.pp_ack = q.ctrl[`RCB_CTL_PINGPONG_ENABLE]; // RL25
                if (i_cmd_valid) begin
                    case ({q.ctrl[`RCB_CTL_MODE8], q.ctrl[`RCB_CTL_MODE7]})
                        2'b10: s.mode = M_CIRC1; // RL10
                        2'b11: s.mode = M_CIRC2; // RL10
                        default: s.mode = M_IDX; // RL11 RL27
                    endcase
                    s.desc = 16'(q.dbase + {7'h00, is_mc, i_cmd.tr,
                                            field, 2'b00}); // RL12
                    s.bcast = i_cmd.bcast;
                    if (is_mc) begin
                        s.word_cnt = (~std_a & i_cmd.wc[4]) ? 6'h01
                                                            : 6'h00; // RL4
                    end else begin
                        s.word_cnt = (i_cmd.wc == 5'h00) ? 6'h20
                                                         : {1'b0, i_cmd.wc};
                    end
                    s.mem = {1'b1, 1'b0, s.desc, 16'h0000};
                    s.dtmr = 12'h000;
                    s.st = S_RD0;
                end
            end
            S_RD0: begin
                if (i_mem_ack) begin
                    s.cw = i_mem_rdata;
                    s.mem = {1'b1, 1'b0, 16'(q.desc + 16'h0001), 16'h0000};
                    s.st = S_RD1;
                end
            end
            S_RD1: begin
                if (i_mem_ack) begin
                    s.top = i_mem_rdata; // RL13 RL22
                    s.mem = {1'b1, 1'b0, 16'(q.desc + `RCB_DW_CUR), 16'h0000};
                    s.st = S_RD2;
                end
            end
            S_RD2: begin
                if (i_mem_ack) begin
                    s.cur = i_mem_rdata;
                    s.mem = {1'b1, 1'b0, 16'(q.desc + `RCB_DW_W4), 16'h0000};
                    s.st = S_RD3;
                end
            end
            S_RD3: begin
                if (i_mem_ack) begin
                    s.w4 = i_mem_rdata;
                    case (q.mode)
                        M_CIRC1: s.ptr = 16'(q.cur + `RCB_HDR_WORDS); // RL14 RL15
                        M_CIRC2: s.ptr = q.cur; // RL22
                        default: s.ptr = q.cw[`RCB_CW_PPSEL] ? q.cur : q.top;
                    endcase
                    s.st = S_XFER;
                end
            end
            S_XFER: begin
                if (q.mem.req & i_mem_ack) begin
                    s.ptr = 16'(q.ptr + 16'h0001);
                    if (~q.mem.we) begin
                        s.tx_valid = 1'b1;
                        s.tx_data = i_mem_rdata;
                    end
                end else if (xfer_rdy & i_rx_valid) begin
                    s.mem = {1'b1, 1'b1, q.ptr, i_rx_data}; // RL14
                end else if (xfer_rdy & i_tx_req) begin
                    s.mem = {1'b1, 1'b0, q.ptr, 16'h0000}; // RL15
                end else if (xfer_rdy & i_end_valid) begin
                    s.fin = i_end;
                    if (q.mode == M_IDX) begin
                        // Ping-pong toggles only while not frozen
                        if (q.pp_ack & ~i_end.err) begin
                            s.cw[`RCB_CW_PPSEL] = ~q.cw[`RCB_CW_PPSEL];
                            s.mem = {1'b1, 1'b1, q.desc, s.cw};
                            s.st = S_WCW;
                        end else begin
                            s.st = S_IDLE;
                        end
                    end else begin
                        s.fin.info[`RCB_INFO_BCAST] = q.bcast; // RL20
                        s.mem = {1'b1, 1'b1,
                                 (q.mode == M_CIRC1) ? q.cur : q.w4,
                                 s.fin.info}; // RL14 RL22
                        s.st = S_INFO;
                    end
                end
            end
            S_INFO: begin
                if (i_mem_ack) begin
                    s.mem = {1'b1, 1'b1, 16'(q.mem.addr + `RCB_TAG_OFS),
                             q.fin.tag}; // RL14 RL15
                    s.st = S_TAG;
                end
            end
            S_TAG: begin
                if (i_mem_ack) begin
                    if (q.mode == M_CIRC1) begin
                        wrap = q.ptr >= q.w4; // RL16
                    end else begin
                        wrap = |(ncaf & ~{1'b0, mlen}); // RL23 RL24
                        s.w4 = (q.w4 & ~{8'h00, mlen}) |
                               (wrap ? 16'h0000
                                     : {8'h00, ncaf[7:0] & mlen}); // RL24
                    end
                    newcur = wrap ? q.top : q.ptr; // RL16 RL24
                    s.cur = newcur;
                    if (q.fin.err & (q.mode == M_CIRC1)) begin
                        s.st = S_IDLE; // RL17
                    end else begin
                        ev[`RCB_ST_FE] = wrap & q.cw[`RCB_CW_FEEN]; // RL21
                        s.mem = {1'b1, 1'b1, 16'(q.desc + `RCB_DW_CUR),
                                 newcur}; // RL17
                        s.st = S_WCA;
                    end
                end
            end
            S_WCA: begin
                if (i_mem_ack) begin
                    if (q.mode == M_CIRC2) begin
                        s.mem = {1'b1, 1'b1, 16'(q.desc + `RCB_DW_W4), q.w4};
                        s.st = S_WW4;
                    end else begin
                        s.st = S_IDLE;
                    end
                end
            end
            S_WW4: begin
                if (i_mem_ack) begin
                    s.st = S_IDLE;
                end
            end
            S_WCW: begin
                if (i_mem_ack) begin
                    s.st = S_IDLE;
                end
            end
            default: begin
                s.st = S_IDLE;
            end
        endcase

        // Stuck access ends the message, no write-back
        if (q.mem.req & ~i_mem_ack &
            (q.dtmr == 12'(`RCB_CYC(`RCB_DMA_TO_US) - 12'h001))) begin
            s.mem.req = 1'b0;
            s.dtmr = 12'h000;
            s.st = S_IDLE; // RL8 RL9
            ev[`RCB_ST_DMA] = 1'b1; // RL8
        end

        s.busy = (s.st != S_IDLE);
        // Set beats a same-cycle clear
        s.status = (q.status & ~clr) | ev;
        msk = {q.mask[`RCB_MSK_NRSP], q.mask[`RCB_MSK_FE],
               q.mask[`RCB_MSK_DMA]};
        s.irq_n = ~|(s.status & msk); // RL9 RL21
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            q <= '0;
            q.st <= S_IDLE;
            q.mode <= M_IDX;
            q.ctrl <= `RCB_CTRL_RST;
            q.mask <= `RCB_MASK_RST;
            q.dbase <= `RCB_DBASE_RST;
            q.irq_n <= 1'b1;
        end else begin
            q <= s;
        end
    end

    assign o_wb_dat = q.wb_dat;
    assign o_wb_ack = q.wb_ack;
    assign o_mem = q.mem;
    assign o_tx_valid = q.tx_valid;
    assign o_tx_data = q.tx_data;
    assign o_word_count = q.word_cnt;
    assign o_std_a = q.std_a;
    assign o_busy = q.busy;
    assign o_message_interrupt_n = q.irq_n;

endmodule

/* File: verification/rcbt_engine_properties.sv */
module rcbt_engine_checker
    import rcbt_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_wb_ack,
    input wire logic i_standard_select_pin,
    input wire logic i_config_lock,
    input wire logic i_cmd_valid,
    input wire logic o_busy,
    input wire rcbt_pkg::rcbt_mem_s o_mem,
    input wire logic i_mem_ack,
    input wire logic o_tx_valid,
    input wire logic o_std_a
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] stall_ff;
    logic [11:0] nxt_stall;
    always_comb begin
        nxt_stall = (o_mem.req && !i_mem_ack) ? stall_ff + 12'h001 : 12'h000;
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) stall_ff <= 12'h000;
        else stall_ff <= nxt_stall;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_wb_req;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    sequence s_ack_pulse;
        o_wb_ack ##1 !o_wb_ack;
    endsequence
    sequence s_cmd_taken;
        i_cmd_valid && !o_busy;
    endsequence
    sequence s_desc_rd;
        o_busy && o_mem.req && !o_mem.we;
    endsequence
    AST_WB_ANSWER: assert property (s_wb_req |=> s_ack_pulse)
        else $error("no single ack pulse");
    AST_WB_CAUSE: assert property (o_wb_ack |-> $past(i_wb_stb))
        else $error("ack without a request");
    AST_CMD_DESC: assert property (s_cmd_taken |=> s_desc_rd)
        else $error("no descriptor read");
    AST_MEM_HOLD: assert property (o_mem.req && !i_mem_ack
        && stall_ff < 12'd1990 |=> o_mem.req && $stable(o_mem))
        else $error("memory request not held");
    AST_DMA_LIMIT: assert property (stall_ff <= 12'd2001)
        else $error("access limit overrun");
    AST_DMA_IDLE: assert property ($fell(o_mem.req) && !$past(i_mem_ack)
        |-> ##[0:2] !o_busy)
        else $error("message not abandoned");
    AST_STD_PIN: assert property (i_config_lock ##1 i_config_lock
        |-> o_std_a == $past(i_standard_select_pin))
        else $error("standard not from pin");
    AST_TX_ACK: assert property (o_tx_valid |-> $past(i_mem_ack))
        else $error("tx word without read");
endmodule

bind rcbt_engine rcbt_engine_checker CHK (
    .i_clk, .i_resetn, .i_wb_cyc, .i_wb_stb, .o_wb_ack,
    .i_standard_select_pin, .i_config_lock, .i_cmd_valid, .o_busy,
    .o_mem, .i_mem_ack, .o_tx_valid, .o_std_a
);

/* File: verification/rcbt_mem_model.sv */
module rcbt_mem_model
    import rcbt_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire rcbt_pkg::rcbt_mem_s i_mem,
    input wire logic [3:0] i_delay,
    input wire logic i_mute,
    output logic o_ack,
    output logic [15:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:255];
    logic [3:0] wait_ff;
    // Plain always: bench preloads words
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ack <= 1'b0;
            wait_ff <= 4'h0;
            o_rdata <= 16'hFFFF;
        end else if (o_ack || !i_mem.req || i_mute) begin
            o_ack <= 1'b0;
            wait_ff <= 4'h0;
            // Idle data toggles so stale words look wrong
            o_rdata <= ~o_rdata;
        end else if (wait_ff < i_delay) begin
            wait_ff <= wait_ff + 4'h1;
        end else begin
            o_ack <= 1'b1;
            o_rdata <= mem[i_mem.addr[7:0]];
            if (i_mem.we) mem[i_mem.addr[7:0]] <= i_mem.wdata;
        end
    end
endmodule

/* File: verification/test_rt_circular_buffer_timeout.sv */
module test_rt_circular_buffer_timeout;
    import rcbt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, wb_cyc, wb_stb, wb_we, lock, std_pin, cmd_valid;
    logic rx_valid, tx_req, end_valid, resp_start, wb_ack, tx_valid, busy;
    logic irq_n, std_a, mem_ack, mute, resp_seen;
    logic [7:0] wb_adr;
    logic [31:0] wb_wdat, wb_rdat;
    logic [15:0] rx_data, tx_data, mem_rdata, rd;
    logic [5:0] word_count;
    logic [3:0] delay;
    rcbt_cmd_s cmd;
    rcbt_end_s fin;
    rcbt_mem_s mem_bus;
    int errors, compares;

    rcbt_engine DUT (
        .i_clk(clk), .i_resetn(rstn), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
        .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(4'hF),
        .i_wb_dat(wb_wdat), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack),
        .i_standard_select_pin(std_pin), .i_config_lock(lock),
        .i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_word_count(word_count),
        .o_std_a(std_a), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
        .i_tx_req(tx_req), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
        .i_end_valid(end_valid), .i_end(fin), .o_busy(busy),
        .i_resp_start(resp_start), .i_resp_seen(resp_seen), .o_mem(mem_bus),
        .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
        .o_message_interrupt_n(irq_n)
    );
    rcbt_mem_model MEM (
        .i_clk(clk), .i_resetn(rstn), .i_mem(mem_bus), .i_delay(delay),
        .i_mute(mute), .o_ack(mem_ack), .o_rdata(mem_rdata)
    );

    task automatic final_report;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int k = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= {16'h0000, d};
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack !== 1'b1 && k < 50);
        if (k >= 50) errors++;
        rd = wb_rdat[15:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_acks(input int n);
        int k = 0;
        while (n > 0 && k < 5000) begin
            @(posedge clk);
            k++;
            if (mem_ack === 1'b1) n--;
        end
        if (n > 0) errors++;
    endtask
    task automatic desc(input logic [7:0] a, input logic [15:0] w0, w1, w2, w3);
        MEM.mem[a] = w0;
        MEM.mem[a + 8'h01] = w1;
        MEM.mem[a + 8'h02] = w2;
        MEM.mem[a + 8'h03] = w3;
    endtask
    task automatic start_cmd(input logic t, s4, input logic [4:0] s, w);
        cmd <= '{t, s, w, s4};
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        wait_acks(4);
    endtask
    task automatic rx_word(input logic [15:0] d);
        rx_valid <= 1'b1;
        rx_data <= d;
        @(posedge clk);
        rx_valid <= 1'b0;
        wait_acks(1);
    endtask
    task automatic end_msg(input logic e, input logic [15:0] info, tag);
        int k = 0;
        fin <= '{e, info, tag};
        end_valid <= 1'b1;
        @(posedge clk);
        end_valid <= 1'b0;
        while (busy !== 1'b0 && k < 100) begin
            @(posedge clk);
            k++;
        end
        if (k >= 100) errors++;
        @(posedge clk);
    endtask

    task automatic t_reset;
        wb(1'b1, 8'h10, 16'hFFFF);
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, 8'(i * 4), 16'h0000);
            chk(rd, 16'h0000);
        end
        chk(16'(irq_n), 16'h0001);
    endtask
    task automatic t_std;
        lock <= 1'b1;
        std_pin <= 1'b1;
        tick(2);
        chk(16'(std_a), 16'h0001);
        std_pin <= 1'b0;
        tick(2);
        chk(16'(std_a), 16'h0000);
        lock <= 1'b0;
        wb(1'b1, 8'h00, 16'h0400);
        tick(2);
        chk(16'(std_a), 16'h0001);
        wb(1'b1, 8'h00, 16'h0000);
    endtask
    task automatic t_mc;
        for (int i = 0; i < 3; i++) begin
            lock <= 1'b1;
            std_pin <= (i != 1);
            tick(2);
            start_cmd(1'b0, 1'b0, (i == 2) ? 5'h1F : 5'h00, 5'h11);
            chk(16'(word_count), (i == 0) ? 16'h0000 : (i == 1) ? 16'h0001
                : 16'h0011);
            end_msg(1'b1, 16'h0000, 16'h0000);
        end
    endtask
    task automatic t_mode1_rx;
        // Upper control bits must be ignored
        desc(8'h0C, 16'hFF80, 16'h0030, 16'h0038, 16'h003B);
        wb(1'b1, 8'h00, 16'h0100);
        wb(1'b1, 8'h04, 16'h0100);
        start_cmd(1'b0, 1'b1, 5'h03, 5'h02);
        rx_word(16'h1234);
        rx_word(16'h5678);
        end_msg(1'b0, 16'h0001, 16'h7777);
        chk(MEM.mem[8'h38], 16'h0021);
        chk(MEM.mem[8'h39], 16'h7777);
        chk(MEM.mem[8'h3A], 16'h1234);
        chk(MEM.mem[8'h3B], 16'h5678);
        chk(MEM.mem[8'h0E], 16'h0030);
        tick(2);
        chk(16'(irq_n), 16'h0000);
        wb(1'b0, 8'h08, 16'h0000);
        chk(rd, 16'h0002);
        wb(1'b1, 8'h08, 16'h0002);
        tick(2);
        chk(16'(irq_n), 16'h0001);
    endtask
    task automatic t_mode1_tx;
        desc(8'h8C, 16'h0080, 16'h0060, 16'h0060, 16'h0090);
        MEM.mem[8'h62] = 16'hBEEF;
        start_cmd(1'b1, 1'b0, 5'h03, 5'h01);
        tx_req <= 1'b1;
        @(posedge clk);
        tx_req <= 1'b0;
        wait_acks(1);
        @(posedge clk);
        chk(16'(tx_valid), 16'h0001);
        chk(tx_data, 16'hBEEF);
        end_msg(1'b1, 16'h0000, 16'h1111);
        chk(MEM.mem[8'h61], 16'h1111);
        chk(MEM.mem[8'h8E], 16'h0060);
        chk(16'(irq_n), 16'h0001);
    endtask
    task automatic t_mode2;
        // Slow memory: every access waits
        delay <= 4'h3;
        wb(1'b1, 8'h00, 16'h0180);
        desc(8'h14, 16'h0300, 16'h0070, 16'h0070, 16'h00A0);
        start_cmd(1'b0, 1'b0, 5'h05, 5'h01);
        rx_word(16'hAAAA);
        end_msg(1'b0, 16'h0020, 16'h0101);
        chk(MEM.mem[8'h70], 16'hAAAA);
        chk(MEM.mem[8'hA0], 16'h0000);
        chk(MEM.mem[8'h16], 16'h0071);
        chk(MEM.mem[8'h17], 16'h00A2);
        start_cmd(1'b0, 1'b0, 5'h05, 5'h01);
        rx_word(16'hBBBB);
        end_msg(1'b0, 16'h0000, 16'h0202);
        chk(MEM.mem[8'h71], 16'hBBBB);
        chk(MEM.mem[8'hA3], 16'h0202);
        chk(MEM.mem[8'h16], 16'h0070);
        chk(MEM.mem[8'h17], 16'h00A0);
        delay <= 4'h0;
    endtask
    task automatic t_mode_undef;
        wb(1'b1, 8'h00, 16'h0080);
        desc(8'h1C, 16'h0000, 16'h00B0, 16'h00C0, 16'h0000);
        start_cmd(1'b0, 1'b0, 5'h07, 5'h01);
        rx_word(16'hCCCC);
        end_msg(1'b0, 16'h0000, 16'h0000);
        chk(MEM.mem[8'hB0], 16'hCCCC);
    endtask
    task automatic t_pingpong;
        for (int i = 1; i >= 0; i--) begin
            wb(1'b1, 8'h00, 16'(i * 4));
            tick(4);
            wb(1'b0, 8'h00, 16'h0000);
            chk(rd & 16'h0204, 16'(i * 16'h0204));
        end
    endtask
    task automatic t_nrsp;
        int lim [4] = '{1750, 3750, 1125, 2625};
        wb(1'b1, 8'h04, 16'h0004);
        for (int i = 0; i < 4; i++) begin
            lock <= 1'b1;
            std_pin <= (i >= 2);
            wb(1'b1, 8'h00, (i % 2 == 1) ? 16'h0200 : 16'h0000);
            resp_start <= 1'b1;
            @(posedge clk);
            resp_start <= 1'b0;
            tick(lim[i] - 30);
            chk(16'(irq_n), 16'h0001);
            tick(60);
            chk(16'(irq_n), 16'h0000);
            wb(1'b1, 8'h08, 16'h0004);
        end
        resp_start <= 1'b1;
        @(posedge clk);
        {resp_start, resp_seen} <= 2'b01;
        @(posedge clk);
        resp_seen <= 1'b0;
        tick(2700);
        chk(16'(irq_n), 16'h0001);
    endtask
    task automatic t_dma;
        wb(1'b1, 8'h04, 16'h0001);
        mute <= 1'b1;
        cmd <= '{1'b0, 5'h03, 5'h01, 1'b0};
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        tick(1990);
        chk(16'(busy), 16'h0001);
        tick(20);
        chk(16'(busy), 16'h0000);
        chk(16'(irq_n), 16'h0000);
        mute <= 1'b0;
        wb(1'b0, 8'h08, 16'h0000);
        chk(rd & 16'h0001, 16'h0001);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        rstn = 1'b0;
        {wb_cyc, wb_stb, wb_we, lock, std_pin, cmd_valid, rx_valid} = '0;
        {tx_req, end_valid, resp_start, resp_seen, mute, delay} = '0;
        {wb_adr, wb_wdat, rx_data, cmd, fin, errors, compares} = '0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset;
        t_std;
        t_mc;
        t_mode1_rx;
        t_mode1_tx;
        t_mode2;
        t_mode_undef;
        t_pingpong;
        t_nrsp;
        t_dma;
        final_report;
    end
    // Run needs about 15000 cycles
    initial begin
        #(30000 * 8);
        errors++;
        final_report;
    end
endmodule
